// ---- pad_host.sv ----
module pad_host
	import pad_pkg::*;
(
	// Device pin drive
	input wire logic [NUM_NARROW-1:0] port_c_out,
	input wire logic [NUM_NARROW-1:0] port_c_oe,
	// Host bus
	output logic [IN_W-1:0] vec,
	output logic address_latch_strobe,
	output logic [AD_W-1:0] ad_in,
	output logic [NUM_NARROW-1:0] port_c_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial vec = '0;
	initial address_latch_strobe = 1'b0;
	initial ad_in = 8'h00;
	// Pin shows the device level where it drives
	assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & vec[7:5]);
	task put(input logic [IN_W-1:0] v, input logic s, input logic [AD_W-1:0] d);
		vec = v;
		address_latch_strobe = s;
		ad_in = d;
	endtask
endmodule

// ---- pad_latch.sv ----
module pad_latch
	import pad_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Host bus
	input wire logic address_latch_strobe,
	input wire logic [AD_W-1:0] ad_in,
	// Demultiplexed low address
	output logic [AD_W-1:0] low_addr
);

	// Follows the bus while the strobe is high, holds after its trailing edge
	wire logic [AD_W-1:0] next_low_addr = address_latch_strobe ? ad_in : low_addr;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			low_addr <= AD_RESET;
		end else begin
			low_addr <= next_low_addr;
		end
	end

endmodule

// ---- pad_monitor.sv ----
module pad_monitor
	import pad_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Inputs
	input wire pad_cfg_t cfg,
	input wire logic [IN_HIADDR_W-1:0] hi_addr,
	input wire logic top_address_or_powerdown,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic address_latch_strobe,
	input wire logic [AD_W-1:0] ad_in,
	input wire logic [IN_PAGE_W-1:0] page_bits,
	input wire logic [NUM_NARROW-1:0] port_c_in,
	// Outputs
	input wire logic [NUM_NARROW-1:0] port_c_out,
	input wire logic [NUM_NARROW-1:0] port_c_oe,
	input wire pad_int_sel_t int_sel,
	input wire logic powered_down,
	input wire logic [NUM_WIDE-1:0] wide_chip_selects_n,
	input wire logic track_ad_drive_en,
	input wire logic [AD_W-1:0] track_porta_addr
);
	logic pd_req;
	logic live;
	logic [IN_W-1:0] iv;
	logic [NUM_TERMS-1:0] hit;
	assign pd_req = cfg.use_powerdown & top_address_or_powerdown;
	assign iv = {write_strobe, read_strobe, page_bits, top_address_or_powerdown & ~cfg.use_powerdown,
		port_c_in & ~cfg.pc_is_select, hi_addr};
	always_comb
		for (int i = 0; i < NUM_TERMS; i++)
			hit[i] = cfg.terms[i].en & ~|((iv ^ cfg.terms[i].match) & cfg.terms[i].care);
	// Decode only judged when the previous edge was live
	always_ff @(posedge sys_clk)
		live <= ~sys_rst & ~pd_req;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> int_sel == INT_SEL_IDLE
		&& &wide_chip_selects_n) else $error("reset left a select on");
	a_pd_idle: assert property (pd_req |=> int_sel == INT_SEL_IDLE && powered_down
		&& &wide_chip_selects_n) else $error("power-down left a select on");
	a_bank_terms: assert property (live |-> int_sel.eprom_bank_selects
		== $past(hit[NUM_EPROM-1:0])) else $error("bank select wrong");
	a_sram_io: assert property (live |-> {int_sel.sram_select, int_sel.io_space_select}
		== {$past(hit[T_SRAM]), $past(hit[T_IO])}) else $error("sram or io select wrong");
	a_wide_sum: assert property (live |-> !wide_chip_selects_n[0]
		== $past(|hit[T_WIDE+3:T_WIDE])) else $error("wide select wrong");
	a_narrow_pin: assert property (live |-> port_c_out[0] == !$past(hit[T_NARROW])
		&& port_c_oe == $past(cfg.pc_is_select)) else $error("port c select wrong");
	a_latch_addr: assert property (address_latch_strobe |=> ##1
		track_porta_addr == $past(ad_in, 2)) else $error("latched address wrong");
	a_track_gate: assert property (track_ad_drive_en |-> int_sel.track_in_select
		&& $past(read_strobe && cfg.track_mode)) else $error("track input drive wrong");
endmodule
bind pad_top pad_monitor mon (.*);

// ---- pad_pkg.sv ----
package pad_pkg;

	// Product-term input vector layout, shared by both arrays
	localparam int IN_W = 15;
	localparam int IN_HIADDR = 0;
	localparam int IN_HIADDR_W = 5;
	localparam int IN_EXT = 5;
	localparam int IN_EXT_W = 3;
	localparam int IN_TOP = 8;
	localparam int IN_PAGE = 9;
	localparam int IN_PAGE_W = 4;
	localparam int IN_RD = 13;
	localparam int IN_WR = 14;

	// Output counts and terms per output
	localparam int NUM_EPROM = 8;
	localparam int NUM_WIDE = 4;
	localparam int WIDE_TERMS = 4;
	localparam int NUM_MID = 4;
	localparam int MID_TERMS = 2;
	localparam int NUM_NARROW = 3;

	// Term slots in the configuration
	localparam int T_EPROM = 0;
	localparam int T_SRAM = T_EPROM + NUM_EPROM;
	localparam int T_IO = T_SRAM + 1;
	localparam int T_TIN = T_IO + 1;
	localparam int T_TAOUT = T_TIN + 1;
	localparam int T_TDOUT = T_TAOUT + 1;
	localparam int T_WIDE = T_TDOUT + 1;
	localparam int T_MID = T_WIDE + NUM_WIDE * WIDE_TERMS;
	localparam int T_NARROW = T_MID + NUM_MID * MID_TERMS;
	localparam int NUM_TERMS = T_NARROW + NUM_NARROW;

	localparam int AD_W = 8;
	localparam logic [AD_W-1:0] AD_RESET = 8'h00;

	// One programmed AND term: care bits select literals, match gives polarity
	typedef struct packed {
		logic en;
		logic [IN_W-1:0] care;
		logic [IN_W-1:0] match;
	} pad_term_t;

	// Non-volatile configuration image
	typedef struct packed {
		logic use_powerdown;
		logic track_mode;
		logic [NUM_NARROW-1:0] pc_is_select;
		pad_term_t [NUM_TERMS-1:0] terms;
	} pad_cfg_t;

	// Internal selects, active high
	typedef struct packed {
		logic [NUM_EPROM-1:0] eprom_bank_selects;
		logic sram_select;
		logic io_space_select;
		logic track_in_select;
		logic track_addr_out_select;
		logic track_data_out_select;
	} pad_int_sel_t;

	localparam pad_int_sel_t INT_SEL_IDLE = '0;

endpackage

// ---- pad_term.sv ----
module pad_term
	import pad_pkg::*;
(
	// Programmed term
	input wire pad_term_t term,
	// Shared decoder inputs
	input wire logic [IN_W-1:0] in_vec,
	// Result
	output logic hit
);

	wire logic [IN_W-1:0] mismatch = (in_vec ^ term.match) & term.care;

	// Unused terms read false, so an empty sum stays deselected
	assign hit = term.en & ~(|mismatch);

endmodule

// ---- pad_top.sv ----
// Behaviour
// - Power-down input high forces outputs inactive
// - Top pin as address is term input
// - Port C pins give address bits 16-18
// - Address bits 11-15 feed every term
// - Four page bits feed every term
// - Read and write strobes feed every term
// - Address latch strobe demultiplexes low address
// - Reset deselects outputs, never a term
// - Eight bank selects, one term each
// - SRAM select from one term
// - I/O space select from one term
// - Track input select gated by read
// - Track address out gated by latch strobe
// - Track data out select drives Port A
// - Four chip selects, four terms each
// - Four chip selects, two terms each
// - Three chip selects, one term each
// - Port C pin: address input or select
// - Both arrays share one input set
module pad_top
	import pad_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Configuration image
	input wire pad_cfg_t cfg,
	// Host address and control
	input wire logic [IN_HIADDR_W-1:0] hi_addr,
	input wire logic top_address_or_powerdown,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic address_latch_strobe,
	input wire logic [AD_W-1:0] ad_in,
	// Page register
	input wire logic [IN_PAGE_W-1:0] page_bits,
	// Port C pins
	input wire logic [NUM_NARROW-1:0] port_c_in,
	output logic [NUM_NARROW-1:0] port_c_out,
	output logic [NUM_NARROW-1:0] port_c_oe,
	// Internal selects
	output pad_int_sel_t int_sel,
	output logic powered_down,
	// External chip selects, active low
	output logic [NUM_WIDE-1:0] wide_chip_selects_n,
	output logic [NUM_MID-1:0] mid_chip_selects_n,
	// Track mode steering
	output logic track_ad_drive_en,
	output logic track_porta_addr_en,
	output logic track_porta_data_en,
	output logic [AD_W-1:0] track_porta_addr
);

	wire logic [AD_W-1:0] low_addr;
	wire logic [NUM_TERMS-1:0] hits;
	wire logic [IN_W-1:0] in_vec;
	wire logic [IN_EXT_W-1:0] ext_addr;
	wire logic pd_req;
	wire logic top_addr;
	wire logic force_off;
	wire logic [NUM_WIDE-1:0] wide_sum;
	wire logic [NUM_MID-1:0] mid_sum;
	wire logic [NUM_NARROW-1:0] narrow_sum;
	wire pad_int_sel_t raw_sel;
	wire pad_int_sel_t next_int_sel;
	wire logic [NUM_WIDE-1:0] next_wide_n;
	wire logic [NUM_MID-1:0] next_mid_n;
	wire logic [NUM_NARROW-1:0] next_pc_out;
	wire logic [NUM_NARROW-1:0] next_pc_oe;
	wire logic next_ad_drive;
	wire logic next_pa_addr;
	wire logic next_pa_data;

	pad_latch u_latch (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.address_latch_strobe(address_latch_strobe),
		.ad_in(ad_in),
		.low_addr(low_addr)
	);

	// Top pin split between power-down and address use
	assign pd_req = cfg.use_powerdown & top_address_or_powerdown;
	assign top_addr = ~cfg.use_powerdown & top_address_or_powerdown;

	// A pin serving as a chip select offers no address bit, so it reads as zero
	assign ext_addr = port_c_in & ~cfg.pc_is_select;

	// Reset is kept out of the vector so no equation can see it
	assign in_vec[IN_HIADDR +: IN_HIADDR_W] = hi_addr;
	assign in_vec[IN_EXT +: IN_EXT_W] = ext_addr;
	assign in_vec[IN_TOP] = top_addr;
	assign in_vec[IN_PAGE +: IN_PAGE_W] = page_bits;
	assign in_vec[IN_RD] = read_strobe;
	assign in_vec[IN_WR] = write_strobe;

	// Every term of both arrays sees the same vector
	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			pad_term u_term (
				.term(cfg.terms[t]),
				.in_vec(in_vec),
				.hit(hits[t])
			);
		end
	endgenerate

	// First array: one term per internal select
	assign raw_sel.eprom_bank_selects = hits[T_EPROM +: NUM_EPROM];
	assign raw_sel.sram_select = hits[T_SRAM];
	assign raw_sel.io_space_select = hits[T_IO];
	assign raw_sel.track_in_select = hits[T_TIN];
	assign raw_sel.track_addr_out_select = hits[T_TAOUT];
	assign raw_sel.track_data_out_select = hits[T_TDOUT];

	// Second array: sums of products
	genvar w;
	generate
		for (w = 0; w < NUM_WIDE; w++) begin : g_wide
			assign wide_sum[w] = |hits[T_WIDE + w * WIDE_TERMS +: WIDE_TERMS];
		end
		for (w = 0; w < NUM_MID; w++) begin : g_mid
			assign mid_sum[w] = |hits[T_MID + w * MID_TERMS +: MID_TERMS];
		end
	endgenerate

	assign narrow_sum = hits[T_NARROW +: NUM_NARROW];

	assign force_off = sys_rst | pd_req;

	assign next_int_sel = force_off ? INT_SEL_IDLE : raw_sel;
	assign next_wide_n = ~(wide_sum & {NUM_WIDE{~force_off}});
	assign next_mid_n = ~(mid_sum & {NUM_MID{~force_off}});
	// Port C selects are active low; an input pin stays undriven
	assign next_pc_out = ~(narrow_sum & {NUM_NARROW{~force_off}});
	assign next_pc_oe = cfg.pc_is_select;

	// Track steering is gated outside the array, so it follows the same forcing
	assign next_ad_drive = cfg.track_mode & next_int_sel.track_in_select & read_strobe;
	assign next_pa_addr = cfg.track_mode & next_int_sel.track_addr_out_select
		& address_latch_strobe;
	// Write qualification lives in the programmed term itself
	assign next_pa_data = cfg.track_mode & next_int_sel.track_data_out_select;

	// Registered outputs: one clock behind the inputs, track_porta_addr two behind ad_in via the latch, glitch free
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			int_sel <= INT_SEL_IDLE;
			wide_chip_selects_n <= '1;
			mid_chip_selects_n <= '1;
			port_c_out <= '1;
			port_c_oe <= '0;
			powered_down <= 1'b0;
			track_ad_drive_en <= 1'b0;
			track_porta_addr_en <= 1'b0;
			track_porta_data_en <= 1'b0;
			track_porta_addr <= AD_RESET;
		end else begin
			int_sel <= next_int_sel;
			wide_chip_selects_n <= next_wide_n;
			mid_chip_selects_n <= next_mid_n;
			port_c_out <= next_pc_out;
			port_c_oe <= next_pc_oe;
			powered_down <= pd_req;
			track_ad_drive_en <= next_ad_drive;
			track_porta_addr_en <= next_pa_addr;
			track_porta_data_en <= next_pa_data;
			track_porta_addr <= low_addr;
		end
	end

endmodule

// ---- tb.sv ----
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb;
	import pad_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	pad_cfg_t cfg = '0;
	int err_count = 0;
	int tests_run = 0;
	logic [IN_W-1:0] vec;
	logic ale;
	logic [AD_W-1:0] ad, pa;
	logic [2:0] pc_in, pc_out, pc_oe;
	pad_int_sel_t sel;
	logic pd, ad_en, pa_en, pd_en;
	logic [3:0] wide_n, mid_n;
	always #12.5 sys_clk = ~sys_clk;
	pad_host host (.port_c_out(pc_out), .port_c_oe(pc_oe), .vec(vec),
		.address_latch_strobe(ale), .ad_in(ad), .port_c_in(pc_in));
	pad_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg(cfg), .hi_addr(vec[4:0]),
		.top_address_or_powerdown(vec[IN_TOP]), .read_strobe(vec[IN_RD]),
		.write_strobe(vec[IN_WR]), .address_latch_strobe(ale), .ad_in(ad),
		.page_bits(vec[12:9]), .port_c_in(pc_in), .port_c_out(pc_out), .port_c_oe(pc_oe),
		.int_sel(sel), .powered_down(pd), .wide_chip_selects_n(wide_n),
		.mid_chip_selects_n(mid_n), .track_ad_drive_en(ad_en), .track_porta_addr_en(pa_en),
		.track_porta_data_en(pd_en), .track_porta_addr(pa));
	function automatic pad_term_t mk(input logic [IN_W-1:0] c, input logic [IN_W-1:0] m);
		return '{1'b1, c, m};
	endfunction
	// Inputs land 2 ns after an edge; results are read one edge later
	task go(input logic [IN_W-1:0] v, input logic s = 1'b0, input logic [AD_W-1:0] d = 8'h00);
		host.put(v, s, d);
		@(posedge sys_clk);
		#2;
	endtask
	task test_done;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task t_reset_sram;
		cfg.terms[T_SRAM] = mk(15'h001f, 15'h0015);
		cfg.terms[T_NARROW] = mk(15'h001f, 15'h0015);
		cfg.pc_is_select = 3'b001;
		go(15'h0015);
		repeat (11) go(15'h0015);
		`CHK(sel, INT_SEL_IDLE)
		`CHK(pc_out, 3'h7)
		sys_rst = 1'b0;
		go(15'h0015);
		go(15'h0015);
		`CHK(sel.sram_select, 1'b1)
		`CHK({pc_out, pc_oe}, 6'h31)
		go(15'h0014);
		`CHK({sel.sram_select, pc_out}, 4'h7)
	endtask
	task t_banks;
		for (int i = 0; i < NUM_EPROM; i++)
			cfg.terms[i] = mk(15'h1e00, IN_W'(i) << IN_PAGE);
		for (int i = 0; i < NUM_EPROM; i++) begin
			go(IN_W'(i) << IN_PAGE);
			`CHK(sel.eprom_bank_selects, 8'h01 << i)
		end
	endtask
	task t_sums;
		cfg.terms[T_WIDE+3] = mk(15'h6000, 15'h2000);
		cfg.terms[T_WIDE+4] = mk(15'h0020, 15'h0020);
		cfg.terms[T_WIDE+8] = mk(15'h0040, 15'h0040);
		cfg.terms[T_MID+1] = mk(15'h6000, 15'h4000);
		go(15'h2000);
		`CHK({wide_n, mid_n}, 8'hef)
		// Pin 0 is a select, so its address bit must read 0
		go(15'h4060);
		`CHK({wide_n, mid_n}, 8'hbe)
	endtask
	task t_top_track;
		cfg.terms[T_IO] = mk(15'h0100, 15'h0100);
		go(15'h0100);
		`CHK({sel.io_space_select, pd}, 2'b10)
		cfg.use_powerdown = 1'b1;
		go(15'h2100);
		`CHK({sel, wide_n, pd}, {INT_SEL_IDLE, 4'hf, 1'b1})
		cfg = '{track_mode: 1'b1, pc_is_select: 3'b000, default: '0};
		cfg.terms[T_TIN] = mk(15'h0000, 15'h0000);
		cfg.terms[T_TAOUT] = mk(15'h0000, 15'h0000);
		cfg.terms[T_TDOUT] = mk(15'h4000, 15'h4000);
		go(15'h2000, 1'b1, 8'h5a);
		`CHK({ad_en, pa_en, pd_en}, 3'b110)
		go(15'h4000, 1'b0, 8'h33);
		`CHK({pa, ad_en, pa_en, pd_en}, 11'h2d1)
		go(15'h0000);
		`CHK(pa, 8'h5a)
	endtask
	initial begin
		#100us;
		err_count++;
		test_done;
	end
	initial begin
		t_reset_sram;
		t_banks;
		t_sums;
		t_top_track;
		test_done;
	end
endmodule
